// ---- core/vpc_consts.svh ----
// Offsets, field positions, reset values and encodings of the protection control block
`ifndef VPC_CONSTS_SVH
`define VPC_CONSTS_SVH
`define VPC_NUM_CH 7
`define VPC_CH_LAST 3'h6
`define VPC_CH1 3'h1
`define VPC_CH6 3'h6
`define VPC_REG_C0 2'h0
`define VPC_REG_C1 2'h1
`define VPC_REG_C2 2'h2
`define VPC_REG_DA 2'h3
`define VPC_OFS_IRQ_STS 8'h80
`define VPC_OFS_IRQ_MSK 8'h84
`define VPC_C0_STATUS 7
`define VPC_C0_POL 6
`define VPC_C0_EN 5
`define VPC_C0_DEB 0
`define VPC_C1_RAW 7
`define VPC_C1_MODE 6
`define VPC_C1_CRS 5
`define VPC_C1_TRIM 0
`define VPC_C2_DACEN 7
`define VPC_C2_HYST 2
`define VPC_C2_SEL 0
`define VPC_TRIM_RST 5'h10
`define VPC_SEL_NONE0 2'h0
`define VPC_SEL_A 2'h1
`define VPC_SEL_B 2'h2
`define VPC_SW_NORMAL 3'h3
`define VPC_SW_REF_NEG 3'h6
`define VPC_SW_REF_POS 3'h5
`define VPC_DEB_NONE 3'h0
`endif

// ---- core/vpc_pkg.sv ----
// Types of the protection control block
package vpc_pkg;
   typedef struct packed {
      logic [6:0] pol;
      logic [6:0] en;
      logic [6:0][2:0] deb_sel;
      logic [6:0] cal_mode;
      logic [6:0] cal_ref;
      logic [6:0][4:0] trim;
      logic [6:0][1:0] hyst;
      logic [6:0][7:0] dac;
      logic dac1_en;
      logic [1:0] sel1;
      logic [1:0] sel6;
      logic [6:0] sync1;
      logic [6:0] sync2;
      logic [6:0] deb_st;
      logic [6:0][6:0] cnt;
      logic [6:0] irq_sts;
      logic [6:0] irq_msk;
      logic irq;
      logic waitreq;
      logic [31:0] rdata;
      logic [6:0] prot_out;
      logic [6:0] cmp_pwr;
      logic [6:0] dac_pwr;
      logic [6:0] sw0;
      logic [6:0] sw1;
      logic [6:0] sw2;
      logic ch1_neg;
      logic ch1_dac;
      logic ch6_p0;
      logic ch6_p1;
   } vpc_state_s;
endpackage : vpc_pkg

// ---- core/vpc_ctrl.sv ----
// Over-voltage protection control: seven channels behind an Avalon-MM slave
//
// Operation
// - Each channel compares its sense input with an 8-bit DAC or another pin.
// - Enable low powers down comparator and DAC, except on channel 1.
// - Channel 1 enable low powers down only its comparator.
// - Channel 1 DAC power follows its own DAC enable bit, reset 0.
// - Three-bit debounce select: none, then 1-2 up to 127-128 clock periods.
// - Debounced status reads 1 when positive input exceeds negative, reset 0.
// - Raw comparator result is readable before debouncing, same encoding, reset 0.
// - Polarity bit passes debounced signal straight when 0, inverted when 1.
// - Debounced status change raises the channel interrupt; polarity picks direction.
// - Mode bit selects normal operation or offset calibration, reset 0.
// - In calibration, reference select picks negative (0) or positive (1) input.
// - Switches: normal on-on-off; reference 0 off-on-on; reference 1 on-off-on.
// - Each channel holds a writable 5-bit offset trim, reset 10000 binary.
// - Each channel holds an 8-bit DAC code, reset 0, output VDD/256 times code.
// - Channels 1 and 6 decode a 2-bit input select; 00 and 11 connect nothing.
`include "vpc_consts.svh"

module vpc_ctrl
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [6:0] raw_compare_in,
   output logic [6:0] debounced_status,
   output logic [6:0] comparator_power_en,
   output logic [6:0] dac_power_en,
   output logic [6:0][7:0] dac_code,
   output logic [6:0][4:0] offset_trim,
   output logic [6:0][1:0] hysteresis_window,
   output logic [6:0] switch0_on,
   output logic [6:0] switch1_on,
   output logic [6:0] switch2_on,
   output logic ch1_select_negative_pin,
   output logic ch1_select_dac,
   output logic ch6_select_positive_pin0,
   output logic ch6_select_positive_pin1,
   output logic protect_irq
);

   vpc_pkg::vpc_state_s st_ff;
   vpc_pkg::vpc_state_s nxt_st;

   // Hold threshold for each debounce code: 2^k - 1 counted cycles
   function automatic logic [6:0] deb_limit(input logic [2:0] k);
      logic [7:0] full;
      full = (8'h01 << k) - 8'h01;
      return full[6:0];
   endfunction : deb_limit

   // Analog switch pattern {s2, s1, s0} from mode and reference select
   function automatic logic [2:0] sw_decode(input logic mode, input logic ref_pos);
      logic [2:0] pat;
      pat = `VPC_SW_NORMAL;
      if (mode)
      begin
         pat = ref_pos ? `VPC_SW_REF_POS : `VPC_SW_REF_NEG;
      end
      return pat;
   endfunction : sw_decode

   // Register read mux; unmapped and reserved bits read as zero
   function automatic logic [7:0] rd_byte(input vpc_pkg::vpc_state_s s,
                                          input logic [7:0] a);
      logic [7:0] d;
      logic [2:0] c;
      d = 8'h00;
      c = a[6:4];
      if (a[7])
      begin
         if (a == `VPC_OFS_IRQ_STS)
         begin
            d = {1'b0, s.irq_sts};
         end
         else if (a == `VPC_OFS_IRQ_MSK)
         begin
            d = {1'b0, s.irq_msk};
         end
      end
      else if (c <= `VPC_CH_LAST)
      begin
         case (a[3:2])
            `VPC_REG_C0:
            begin
               d[`VPC_C0_STATUS] = s.deb_st[c];
               d[`VPC_C0_POL] = s.pol[c];
               d[`VPC_C0_EN] = s.en[c];
               d[`VPC_C0_DEB +: 3] = s.deb_sel[c];
            end
            `VPC_REG_C1:
            begin
               d[`VPC_C1_RAW] = s.sync2[c];
               d[`VPC_C1_MODE] = s.cal_mode[c];
               d[`VPC_C1_CRS] = s.cal_ref[c];
               d[`VPC_C1_TRIM +: 5] = s.trim[c];
            end
            `VPC_REG_C2:
            begin
               d[`VPC_C2_HYST +: 2] = s.hyst[c];
               if (c == `VPC_CH1)
               begin
                  d[`VPC_C2_DACEN] = s.dac1_en;
                  d[`VPC_C2_SEL +: 2] = s.sel1;
               end
               else if (c == `VPC_CH6)
               begin
                  d[`VPC_C2_SEL +: 2] = s.sel6;
               end
            end
            default:
            begin
               d = s.dac[c];
            end
         endcase
      end
      return d;
   endfunction : rd_byte

   // Next state: bus slave, registers, debounce, events and registered outputs
   always_comb
   begin
      logic req;
      logic [2:0] c;
      logic [7:0] wd;
      logic [6:0] raw_eff;
      logic [6:0] lim;
      logic [2:0] pat;
      logic evt;
      nxt_st = st_ff;
      req = avs_read | avs_write;
      c = avs_address[6:4];
      wd = avs_writedata[7:0];
      raw_eff = 7'h00;
      lim = 7'h00;
      pat = 3'h0;
      evt = 1'b0;

      // One wait cycle per access; the read byte is captured while waiting
      if (req && st_ff.waitreq)
      begin
         nxt_st.waitreq = 1'b0;
         nxt_st.rdata = {24'h000000, rd_byte(st_ff, avs_address)};
      end
      else
      begin
         nxt_st.waitreq = 1'b1;
      end

      // A write takes effect on the edge that ends the access
      if (avs_write && !st_ff.waitreq && avs_byteenable[0])
      begin
         if (avs_address[7])
         begin
            if (avs_address == `VPC_OFS_IRQ_STS)
            begin
               nxt_st.irq_sts = st_ff.irq_sts & ~wd[6:0];
            end
            else if (avs_address == `VPC_OFS_IRQ_MSK)
            begin
               nxt_st.irq_msk = wd[6:0];
            end
         end
         else if (c <= `VPC_CH_LAST)
         begin
            case (avs_address[3:2])
               `VPC_REG_C0:
               begin
                  nxt_st.pol[c] = wd[`VPC_C0_POL];
                  nxt_st.en[c] = wd[`VPC_C0_EN];
                  nxt_st.deb_sel[c] = wd[`VPC_C0_DEB +: 3];
               end
               `VPC_REG_C1:
               begin
                  nxt_st.cal_mode[c] = wd[`VPC_C1_MODE];
                  nxt_st.cal_ref[c] = wd[`VPC_C1_CRS];
                  nxt_st.trim[c] = wd[`VPC_C1_TRIM +: 5];
               end
               `VPC_REG_C2:
               begin
                  nxt_st.hyst[c] = wd[`VPC_C2_HYST +: 2];
                  if (c == `VPC_CH1)
                  begin
                     nxt_st.dac1_en = wd[`VPC_C2_DACEN];
                     nxt_st.sel1 = wd[`VPC_C2_SEL +: 2];
                  end
                  else if (c == `VPC_CH6)
                  begin
                     nxt_st.sel6 = wd[`VPC_C2_SEL +: 2];
                  end
               end
               default:
               begin
                  nxt_st.dac[c] = wd;
               end
            endcase
         end
      end

      // Comparator outputs are asynchronous to clk_sys: two-stage synchroniser
      nxt_st.sync1 = raw_compare_in;
      nxt_st.sync2 = st_ff.sync1;
      // A powered-down comparator reads as low, so a disabled channel stays quiet
      raw_eff = st_ff.sync2 & st_ff.en;

      for (int i = 0; i < `VPC_NUM_CH; i++)
      begin
         lim = deb_limit(st_ff.deb_sel[i]);
         nxt_st.cnt[i] = 7'h00;
         if (st_ff.deb_sel[i] == `VPC_DEB_NONE)
         begin
            nxt_st.deb_st[i] = raw_eff[i];
         end
         else if (raw_eff[i] != st_ff.deb_st[i])
         begin
            // Sampling phase of the input adds up to one cycle, hence n-1..n
            if (st_ff.cnt[i] >= lim - 7'h01)
            begin
               nxt_st.deb_st[i] = raw_eff[i];
            end
            else
            begin
               nxt_st.cnt[i] = st_ff.cnt[i] + 7'h01;
            end
         end

         // Only the transition away from the polarity level counts as an event
         evt = (nxt_st.deb_st[i] != st_ff.deb_st[i]) &&
               (nxt_st.deb_st[i] != st_ff.pol[i]);
         if (evt)
         begin
            // Set applied after the clear so a coincident event is kept
            nxt_st.irq_sts[i] = 1'b1;
         end

         nxt_st.prot_out[i] = nxt_st.deb_st[i] ^ nxt_st.pol[i];

         pat = sw_decode(nxt_st.cal_mode[i], nxt_st.cal_ref[i]);
         nxt_st.sw0[i] = pat[0];
         nxt_st.sw1[i] = pat[1];
         nxt_st.sw2[i] = pat[2];

         nxt_st.cmp_pwr[i] = nxt_st.en[i];
         nxt_st.dac_pwr[i] = nxt_st.en[i];
      end

      // Channel 1 DAC runs on its own enable, independent of the channel enable
      nxt_st.dac_pwr[`VPC_CH1] = nxt_st.dac1_en;

      // Input routing for the two channels with a selectable source
      nxt_st.ch1_neg = (nxt_st.sel1 == `VPC_SEL_A);
      nxt_st.ch1_dac = (nxt_st.sel1 == `VPC_SEL_B);
      nxt_st.ch6_p0 = (nxt_st.sel6 == `VPC_SEL_A);
      nxt_st.ch6_p1 = (nxt_st.sel6 == `VPC_SEL_B);

      // Level interrupt, taken from next values so it tracks status with no lag
      nxt_st.irq = |(nxt_st.irq_sts & nxt_st.irq_msk);
   end

   // State register; reset values are constants only
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= '0;
         st_ff.trim <= {`VPC_NUM_CH{`VPC_TRIM_RST}};
         st_ff.waitreq <= 1'b1;
         st_ff.sw0 <= 7'h7f;
         st_ff.sw1 <= 7'h7f;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // Every output is a field of the state register
   assign avs_readdata = st_ff.rdata;
   assign avs_waitrequest = st_ff.waitreq;
   assign debounced_status = st_ff.prot_out;
   assign comparator_power_en = st_ff.cmp_pwr;
   assign dac_power_en = st_ff.dac_pwr;
   assign dac_code = st_ff.dac;
   assign offset_trim = st_ff.trim;
   assign hysteresis_window = st_ff.hyst;
   assign switch0_on = st_ff.sw0;
   assign switch1_on = st_ff.sw1;
   assign switch2_on = st_ff.sw2;
   assign ch1_select_negative_pin = st_ff.ch1_neg;
   assign ch1_select_dac = st_ff.ch1_dac;
   assign ch6_select_positive_pin0 = st_ff.ch6_p0;
   assign ch6_select_positive_pin1 = st_ff.ch6_p1;
   assign protect_irq = st_ff.irq;

endmodule : vpc_ctrl

// ---- testbench/vpc_chk.sv ----
// Port checks of the protection control block
module vpc_chk
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [6:0] debounced_status,
   input wire logic [6:0] comparator_power_en,
   input wire logic [6:0] dac_power_en,
   input wire logic [6:0][7:0] dac_code,
   input wire logic [6:0][4:0] offset_trim,
   input wire logic [6:0] switch0_on,
   input wire logic [6:0] switch1_on,
   input wire logic [6:0] switch2_on,
   input wire logic ch1_select_negative_pin,
   input wire logic ch1_select_dac,
   input wire logic ch6_select_positive_pin0,
   input wire logic ch6_select_positive_pin1,
   input wire logic protect_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Request taken, then exactly one wait state, then waitrequest returns
   sequence req_taken;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence one_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   // A register moves only at the edge that completes a write
   sequence write_done;
      $past(avs_write) && !$past(avs_waitrequest);
   endsequence
   one_wait_a: assert property (req_taken |=> one_answer)
      else $error("waitrequest not one cycle");
   dac_pwr_a: assert property ((dac_power_en & 7'h7d) == (comparator_power_en & 7'h7d))
      else $error("dac power differs from enable");
   sw_pair_a: assert property (((switch0_on & switch1_on & ~switch2_on)
      | (~switch0_on & switch1_on & switch2_on) | (switch0_on & ~switch1_on & switch2_on))
      == 7'h7f) else $error("switch combination illegal");
   sel_one_a: assert property (!(ch1_select_negative_pin && ch1_select_dac))
      else $error("channel 1 selects two inputs");
   sel_six_a: assert property (!(ch6_select_positive_pin0 && ch6_select_positive_pin1))
      else $error("channel 6 selects two inputs");
   trim_hold_a: assert property (!$stable(offset_trim) |-> write_done)
      else $error("trim moved without a write");
   dac_hold_a: assert property (!$stable(dac_code) |-> write_done)
      else $error("dac code moved without a write");
   irq_cause_a: assert property ($rose(protect_irq) && !$past(avs_write) |->
      ##[0:1] debounced_status != $past(debounced_status, 2))
      else $error("interrupt without status change");
endmodule : vpc_chk

bind vpc_ctrl vpc_chk u_chk (.clk_sys, .rst, .avs_read, .avs_write, .avs_waitrequest,
   .debounced_status, .comparator_power_en, .dac_power_en, .dac_code, .offset_trim,
   .switch0_on, .switch1_on, .switch2_on, .ch1_select_negative_pin, .ch1_select_dac,
   .ch6_select_positive_pin0, .ch6_select_positive_pin1, .protect_irq);

// ---- testbench/vpc_cmp_model.sv ----
// Behavioural comparators behind the protection channels
module vpc_cmp_model
#(
   parameter logic [4:0] THR = 5'h0b
)
(
   input wire logic [6:0] pwr,
   input wire logic [6:0] cal,
   input wire logic [6:0][4:0] trim,
   input wire logic [6:0] lvl,
   output logic [6:0] raw
);
   timeunit 1ns;
   timeprecision 1ns;
   // Unpowered comparator reads low; calibration trips once trim passes the offset
   always_comb
   begin
      for (int i = 0; i < 7; i++)
         raw[i] = pwr[i] & (cal[i] ? (trim[i] > THR) : lvl[i]);
   end
endmodule : vpc_cmp_model

// ---- testbench/testbench.sv ----
// Self-checking bench of the protection control block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [4:0] THR = 5'h0b;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, c1n, c1d, c6a, c6b, irq;
   logic [6:0] raw, dbs, cpe, dpe, s0, s1, s2;
   logic [6:0] lvl = 7'h00;
   logic [6:0][7:0] dac;
   logic [6:0][4:0] trim;
   logic [6:0][1:0] hys;
   logic [7:0] rd_v;
   logic [4:0] v1, v2;
   logic [11:0] swv [3] = '{12'h310, 12'h650, 12'h570};
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;
   always #50 clk_sys = ~clk_sys;
   vpc_ctrl u_dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .raw_compare_in(raw),
      .debounced_status(dbs), .comparator_power_en(cpe), .dac_power_en(dpe),
      .dac_code(dac), .offset_trim(trim), .hysteresis_window(hys), .switch0_on(s0),
      .switch1_on(s1), .switch2_on(s2), .ch1_select_negative_pin(c1n),
      .ch1_select_dac(c1d), .ch6_select_positive_pin0(c6a),
      .ch6_select_positive_pin1(c6b), .protect_irq(irq));
   vpc_cmp_model #(.THR(THR)) u_cmp (.pwr(cpe), .cal(s2), .trim, .lvl, .raw);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Bus cycles hold the request until waitrequest is seen low at an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= 1'b1;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(negedge clk_sys);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rd_v = avs_readdata[7:0];
      avs_read <= 1'b0;
   endtask : rd
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // Ceiling well above the roughly 1200 cycles the run needs
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      for (int c = 0; c < 7; c++)
      begin
         rd(8'(c * 16));
         chk(rd_v, 8'h00);
         rd(8'(c * 16 + 4));
         chk(rd_v, 8'h10);
         rd(8'(c * 16 + 8));
         chk(rd_v, 8'h00);
         rd(8'(c * 16 + 12));
         chk(rd_v, 8'h00);
      end
      $display("reset values done");
      wr(8'h3c, 8'ha5);
      chk(dac[3], 8'ha5);
      rd(8'h8c);
      chk(rd_v, 8'h00);
      wr(8'h00, 8'h20);
      wr(8'h10, 8'h20);
      chk({1'b0, dpe}, 8'h01);
      wr(8'h18, 8'h80);
      wr(8'h10, 8'h00);
      chk({1'b0, cpe}, 8'h01);
      chk({1'b0, dpe}, 8'h03);
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h18, 8'(c));
         wr(8'h68, 8'(c));
         chk({c6b, c6a, c1d, c1n}, {4'h0, c == 2, c == 1, c == 2, c == 1});
      end
      foreach (swv[i])
      begin
         wr(8'h24, swv[i][7:0]);
         chk({s2[2], s1[2], s0[2]}, swv[i][11:8]);
      end
      $display("control outputs done");
      wr(8'h20, 8'h20);
      wr(8'h28, 8'h0c);
      chk({6'h0, hys[2]}, 8'h03);
      wr(8'h28, 8'h00);
      chk({6'h0, hys[2]}, 8'h00);
      v1 = 5'h00;
      v2 = 5'h1f;
      do
      begin
         wr(8'h24, {3'h3, v1});
         repeat (4) @(posedge clk_sys);
         rd(8'h24);
         v1 = v1 + 5'(!rd_v[7]);
      end while (!rd_v[7]);
      do
      begin
         wr(8'h24, {3'h3, v2});
         repeat (4) @(posedge clk_sys);
         rd(8'h24);
         v2 = v2 - 5'(rd_v[7]);
      end while (rd_v[7]);
      wr(8'h24, {3'h3, 5'(({1'b0, v1} + v2) >> 1)});
      chk({3'h0, v1}, {3'h0, THR + 5'h01});
      chk({3'h0, trim[2]}, {3'h0, THR});
      $display("calibration done");
      wr(8'h84, 8'h01);
      for (int k = 0; k < 8; k++)
      begin
         wr(8'h00, {5'h04, 3'(k)});
         lvl[0] <= 1'b1;
         n = 0;
         while (dbs[0] !== 1'b1)
         begin
            @(posedge clk_sys);
            n++;
         end
         chk(8'(n >= (1 << k) - 1 && n <= (1 << k) + 3), 8'h01);
         rd(8'h00);
         chk(rd_v, {5'h14, 3'(k)});
         chk({7'h0, irq}, 8'h01);
         wr(8'h80, 8'h01);
         lvl[0] <= 1'b0;
         while (dbs[0] !== 1'b0) @(posedge clk_sys);
         @(negedge clk_sys);
         chk({7'h0, irq}, 8'h00);
      end
      wr(8'h00, 8'h60);
      chk({7'h0, dbs[0]}, 8'h01);
      lvl[0] <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk({dbs[0], irq}, 8'h00);
      lvl[0] <= 1'b0;
      repeat (8) @(posedge clk_sys);
      chk({dbs[0], irq}, 8'h03);
      wr(8'h84, 8'h00);
      chk({7'h0, irq}, 8'h00);
      $display("debounce and interrupt done");
      end_of_test();
   end
endmodule : testbench
